// ---- rtl/wake_pkg.sv ----
// constants for the keyboard/mouse wake detector and general wake routing.
// assumes a 10 MHz mclk and an APB master with 32-bit data.
package wake_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h13;
	localparam logic [7:0] IDX_KBD_DATA = 8'h16;
	localparam logic [7:0] IDX_MOUSE_DATA = 8'h17;
	localparam logic [7:0] IDX_ROUTE_EN = 8'h1a;
	localparam logic [7:0] IDX_MATCH0 = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h28;
	localparam logic [7:0] IDX_SOFT_RST = 8'h29;
	// reset values
	localparam logic [7:0] ROUTE_EN_RESET = 8'hff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// control field positions
	localparam int CTRL_PARITY_OFF_BIT = 7;
	localparam int CTRL_MOUSE_LSB = 4;
	localparam int CTRL_KBD_LSB = 0;
	// status bits (write one to clear)
	localparam int STAT_KBD_BIT = 0;
	localparam int STAT_MOUSE_BIT = 1;
	// keyboard configuration boundaries and byte values
	localparam logic [3:0] KBD_OFF = 4'h0;
	localparam logic [3:0] KBD_PASSWORD_MIN = 4'h8;
	localparam logic [3:0] KBD_PASSWORD_BIAS = 4'h7;
	localparam logic [3:0] KBD_RAW_BIAS = 4'h1;
	localparam logic [7:0] MATCH_ANY = 8'h00;
	localparam logic [7:0] BYTE_EXT_PREFIX = 8'he0;
	localparam logic [7:0] BYTE_BREAK_PREFIX = 8'hf0;
	localparam int MATCH_DEPTH = 8;
	// mouse configuration codes
	typedef enum logic [2:0] {
		MOUSE_OFF, MOUSE_ANY, MOUSE_LEFT, MOUSE_LEFT_DBL,
		MOUSE_RIGHT, MOUSE_RIGHT_DBL, MOUSE_BTN, MOUSE_BTN_DBL
	} mouse_cfg_t;
	localparam int MOUSE_SYNC_BIT = 3;
	localparam logic [1:0] MOUSE_LAST_BYTE = 2'd2;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int LINK_IDLE_NS = 200000;
	localparam int LINK_IDLE_CYCLES = LINK_IDLE_NS / CLK_PERIOD_NS;
	localparam int DBL_CLICK_NS = 500000000;
	localparam int DBL_CLICK_CYCLES = DBL_CLICK_NS / CLK_PERIOD_NS;
	localparam int FRAME_LAST_BIT = 10;
endpackage : wake_pkg

// ---- rtl/ps2_wake_detector.sv ----
// keyboard/mouse wake pattern detector with general wake input routing, APB slave.
// assumes link pins and wake inputs are asynchronous; all logic runs on mclk.
// Behaviour
// (R1) routing enables load all ones on reset
// (R2) absent main supply, only enabled inputs pass
// (R3) enable bit n gates wake input n
// (R4) keyboard and mouse detectors fully independent
// (R5) runs without the keyboard controller
// (R6) any key, password, raw byte sequence
// (R7) software: raw mode 1, two zero bytes
// (R8) zero match byte accepts any byte
// (R9) password drops prefix and break bytes
// (R10) software: password keys have one-byte codes
// (R11) password field is key count plus seven
// (R12) password codes compared from match byte 0
// (R13) raw mode compares every received byte
// (R14) raw field is byte count minus one
// (R15) raw bytes compared from match byte 0
// (R16) mouse: movement, clicks or double-clicks
// (R17) software picks mouse event in field
// (R18) mouse field encodings decoded per table
// (R19) keyboard field zero disables keyboard detection
// (R20) software clears field before changing it
// (R21) control bit 7 turns parity check off
// (R22) wake only on full consecutive match
// (R23) frames sampled on falling link clock edges
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module ps2_wake_detector import wake_pkg::*; #(
	parameter int DBL_CYCLES = DBL_CLICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic kbd_clk,
	input wire logic kbd_data,
	input wire logic mouse_clk,
	input wire logic mouse_data,
	input wire logic main_power_good,
	input wire logic [7:0] general_wake_in,
	output logic [7:0] routed_wake,
	output logic kbd_wake_event,
	output logic mouse_wake_event
);
	localparam int DBL_W = $clog2(DBL_CYCLES + 1);
	localparam int IDLE_W = $clog2(LINK_IDLE_CYCLES + 1);

	// synchronisers: s1 feeds only s2; s3 is a delayed s2 for edge finding
	logic [12:0] s1, s2, s3;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 13'h1f_ff;
			s2 <= 13'h1f_ff;
			s3 <= 13'h1f_ff;
		end else begin
			s1 <= {general_wake_in, main_power_good, mouse_data, mouse_clk, kbd_data, kbd_clk};
			s2 <= s1;
			s3 <= s2;
		end
	end

	// register file
	logic [7:0] route_en, ctrl, status, kbd_shift, mouse_shift;
	logic [7:0] match_byte [MATCH_DEPTH];
	logic [7:0] next_route_en, next_ctrl, next_status, next_kbd_shift, next_mouse_shift;
	logic [7:0] next_match_byte [MATCH_DEPTH];
	logic [31:0] next_prdata;
	logic next_pslverr, wr_en, soft_rst, setup;
	logic kbd_hit, mouse_hit;
	logic [1:0] rx_valid;
	logic [15:0] rx_byte;
	wire logic [3:0] kbd_cfg = ctrl[CTRL_KBD_LSB +: 4];
	wire mouse_cfg_t mouse_cfg = mouse_cfg_t'(ctrl[CTRL_MOUSE_LSB +: 3]);
	wire logic parity_off = ctrl[CTRL_PARITY_OFF_BIT];

	function automatic logic is_mapped(input logic [7:0] idx);
		return idx == IDX_CTRL || idx == IDX_KBD_DATA || idx == IDX_MOUSE_DATA || idx == IDX_ROUTE_EN
			|| (idx >= IDX_MATCH0 && idx < IDX_STATUS) || idx == IDX_STATUS || idx == IDX_SOFT_RST;
	endfunction : is_mapped

	// read data and error are latched in the setup cycle so they come from flops
	assign setup = psel & ~penable;
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite & ~pslverr;
	assign soft_rst = wr_en && paddr[7:2] == IDX_SOFT_RST[5:0] && pwdata[0];

	always_comb begin
		next_route_en = route_en;
		next_ctrl = ctrl;
		next_match_byte = match_byte;
		next_prdata = prdata;
		next_pslverr = pslverr;
		next_kbd_shift = kbd_shift;
		next_mouse_shift = mouse_shift;
		next_status = status;
		if (setup) begin
			next_pslverr = !is_mapped({2'b00, paddr[7:2]}) || paddr[1:0] != 2'b00;
			next_prdata = 32'h0000_0000;
			unique case ({2'b00, paddr[7:2]})
				IDX_CTRL: next_prdata[7:0] = ctrl;
				IDX_KBD_DATA: next_prdata[7:0] = kbd_shift;
				IDX_MOUSE_DATA: next_prdata[7:0] = mouse_shift;
				IDX_ROUTE_EN: next_prdata[7:0] = route_en;
				IDX_STATUS: next_prdata[7:0] = status;
				default: begin
					if (paddr[7:5] == IDX_MATCH0[5:3])
						next_prdata[7:0] = match_byte[paddr[4:2]];
				end
			endcase
			// refused accesses read as zero, even a misaligned hit on a real register
			if (next_pslverr)
				next_prdata = 32'h0000_0000;
		end
		if (wr_en) begin
			if (paddr[7:2] == IDX_CTRL[5:0])
				next_ctrl = pwdata[7:0];
			if (paddr[7:2] == IDX_ROUTE_EN[5:0])
				next_route_en = pwdata[7:0];
			if (paddr[7:5] == IDX_MATCH0[5:3])
				next_match_byte[paddr[4:2]] = pwdata[7:0];
			if (paddr[7:2] == IDX_STATUS[5:0])
				next_status = status & ~pwdata[7:0];
		end
		// shift copies only kept while that detector is on
		if (rx_valid[0] && kbd_cfg != KBD_OFF)
			next_kbd_shift = rx_byte[7:0];
		if (rx_valid[1] && mouse_cfg != MOUSE_OFF)
			next_mouse_shift = rx_byte[15:8];
		// hardware set wins over a same-cycle clear
		if (kbd_hit)
			next_status[STAT_KBD_BIT] = 1'b1;
		if (mouse_hit)
			next_status[STAT_MOUSE_BIT] = 1'b1;
		if (soft_rst) begin
			next_route_en = ROUTE_EN_RESET; // see (R1)
			next_ctrl = CTRL_RESET;
			next_kbd_shift = 8'h00;
			next_mouse_shift = 8'h00;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			route_en <= ROUTE_EN_RESET; // see (R1)
			ctrl <= CTRL_RESET;
			status <= 8'h00;
			kbd_shift <= 8'h00;
			mouse_shift <= 8'h00;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			for (int i = 0; i < MATCH_DEPTH; i++)
				match_byte[i] <= 8'h00;
		end else begin
			route_en <= next_route_en;
			ctrl <= next_ctrl;
			status <= next_status;
			kbd_shift <= next_kbd_shift;
			mouse_shift <= next_mouse_shift;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			match_byte <= next_match_byte;
		end
	end

	// wake routing while main supply is absent
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			routed_wake <= 8'h00;
		else
			routed_wake <= s2[12:5] & route_en & {8{~s2[4]}}; // see (R2) (R3)
	end

	// one receiver per link, own state each so neither disturbs the other; see (R4)
	for (genvar g = 0; g < 2; g++) begin : g_rx
		logic [3:0] bit_cnt, next_bit_cnt;
		logic [9:0] frame, next_frame;
		logic [IDLE_W-1:0] idle, next_idle;
		logic fall, done, ok, valid;
		logic [7:0] data;
		assign fall = s3[2 * g] & ~s2[2 * g]; // see (R23)
		assign ok = ~frame[0] & s2[2 * g + 1] & (parity_off | ^frame[9:1]); // see (R21)
		always_comb begin
			next_bit_cnt = bit_cnt;
			next_frame = frame;
			next_idle = idle;
			done = 1'b0;
			if (fall) begin
				next_idle = '0;
				next_frame = {s2[2 * g + 1], frame[9:1]};
				if (bit_cnt == 4'(FRAME_LAST_BIT)) begin
					next_bit_cnt = 4'd0;
					done = 1'b1;
				end else if (bit_cnt != 4'd0 || !s2[2 * g + 1])
					next_bit_cnt = bit_cnt + 4'd1;
			end else if (bit_cnt != 4'd0) begin
				// stalled frame: drop it so the next start bit resyncs
				if (idle == IDLE_W'(LINK_IDLE_CYCLES)) begin
					next_bit_cnt = 4'd0;
					next_idle = '0;
				end else
					next_idle = idle + 1'b1;
			end
		end
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				bit_cnt <= 4'd0;
				frame <= 10'h3ff;
				idle <= '0;
				valid <= 1'b0;
				data <= 8'h00;
			end else begin
				bit_cnt <= next_bit_cnt;
				frame <= next_frame;
				idle <= next_idle;
				valid <= done & ok;
				data <= done ? frame[8:1] : data;
			end
		end
		assign rx_valid[g] = valid;
		assign rx_byte[8 * g +: 8] = data;
	end

	// keyboard matcher, independent of any keyboard controller; see (R5)
	logic [2:0] kpos, next_kpos;
	logic after_break, next_after_break;
	logic [3:0] klen;
	logic password, kconsider, kmatch, klast;
	wire logic [7:0] kbyte = rx_byte[7:0];
	assign password = kbd_cfg >= KBD_PASSWORD_MIN;
	assign klen = password ? kbd_cfg - KBD_PASSWORD_BIAS : kbd_cfg + KBD_RAW_BIAS; // see (R11) (R14)
	assign kmatch = match_byte[kpos] == MATCH_ANY || match_byte[kpos] == kbyte; // see (R8) (R12) (R15)
	assign klast = {1'b0, kpos} + 4'd1 == klen;
	always_comb begin
		next_kpos = kpos;
		next_after_break = after_break;
		kbd_hit = 1'b0;
		kconsider = rx_valid[0] && kbd_cfg != KBD_OFF; // see (R19)
		if (kconsider && password) begin
			// prefixes and the code after a break prefix are skipped
			if (kbyte == BYTE_BREAK_PREFIX)
				next_after_break = 1'b1; // see (R9)
			if (kbyte == BYTE_BREAK_PREFIX || kbyte == BYTE_EXT_PREFIX || after_break)
				kconsider = 1'b0;
			if (after_break && kbyte != BYTE_BREAK_PREFIX && kbyte != BYTE_EXT_PREFIX)
				next_after_break = 1'b0;
		end
		if (kconsider) begin // see (R6) (R13)
			if (kmatch && klast) begin
				kbd_hit = 1'b1; // see (R22)
				next_kpos = 3'd0;
			end else if (kmatch)
				next_kpos = kpos + 3'd1;
			else
				next_kpos = 3'd0; // see (R22)
		end
		if (kbd_cfg == KBD_OFF) begin
			next_kpos = 3'd0;
			next_after_break = 1'b0;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			kpos <= 3'd0;
			after_break <= 1'b0;
			kbd_wake_event <= 1'b0;
		end else begin
			kpos <= next_kpos;
			after_break <= next_after_break;
			kbd_wake_event <= kbd_hit;
		end
	end

	// mouse matcher: three-byte packets, clicks seen on button release
	logic [1:0] midx, next_midx;
	logic [2:0] btn, next_btn, pend_btn, next_pend_btn, sel, clicks;
	logic moved, next_moved, pkt_end, dbl_mode;
	logic [DBL_W-1:0] dbl_timer, next_dbl_timer;
	wire logic [7:0] mbyte = rx_byte[15:8];
	always_comb begin
		unique case (mouse_cfg) // see (R18)
			MOUSE_LEFT, MOUSE_LEFT_DBL: sel = 3'b001;
			MOUSE_RIGHT, MOUSE_RIGHT_DBL: sel = 3'b010;
			MOUSE_OFF, MOUSE_ANY, MOUSE_BTN, MOUSE_BTN_DBL: sel = 3'b111;
		endcase
		dbl_mode = mouse_cfg == MOUSE_LEFT_DBL || mouse_cfg == MOUSE_RIGHT_DBL || mouse_cfg == MOUSE_BTN_DBL;
		next_midx = midx;
		next_btn = btn;
		next_pend_btn = pend_btn;
		next_moved = moved;
		pkt_end = 1'b0;
		mouse_hit = 1'b0;
		next_dbl_timer = dbl_timer == '0 ? '0 : dbl_timer - 1'b1;
		clicks = btn & ~pend_btn;
		if (rx_valid[1] && mouse_cfg != MOUSE_OFF) begin
			if (midx == 2'd0) begin
				// a first byte without the sync bit is out of step; wait
				if (mbyte[MOUSE_SYNC_BIT]) begin
					next_pend_btn = mbyte[2:0];
					next_moved = 1'b0;
					next_midx = 2'd1;
				end
			end else begin
				next_moved = moved | (mbyte != 8'h00);
				next_midx = midx == MOUSE_LAST_BYTE ? 2'd0 : midx + 2'd1;
				pkt_end = midx == MOUSE_LAST_BYTE;
			end
		end
		if (pkt_end) begin // see (R16)
			next_btn = pend_btn;
			if (mouse_cfg == MOUSE_ANY)
				mouse_hit = next_moved || pend_btn != btn;
			else if (|(clicks & sel)) begin
				if (!dbl_mode)
					mouse_hit = 1'b1;
				else if (dbl_timer != '0) begin
					mouse_hit = 1'b1;
					next_dbl_timer = '0;
				end else
					next_dbl_timer = DBL_W'(DBL_CYCLES);
			end
		end
		if (mouse_cfg == MOUSE_OFF) begin
			next_midx = 2'd0;
			next_dbl_timer = '0;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			midx <= 2'd0;
			btn <= 3'b000;
			pend_btn <= 3'b000;
			moved <= 1'b0;
			dbl_timer <= '0;
			mouse_wake_event <= 1'b0;
		end else begin
			midx <= next_midx;
			btn <= next_btn;
			pend_btn <= next_pend_btn;
			moved <= next_moved;
			dbl_timer <= next_dbl_timer;
			mouse_wake_event <= mouse_hit;
		end
	end

	// checks
	a_route_reset: assert property (@(posedge mclk) disable iff (!rst_n) soft_rst |=> route_en == 8'hff) // see (R1)
		else $error("routing enables not all ones after soft reset");
	a_route_gate: assert property (@(posedge mclk) disable iff (!rst_n) // see (R2)
		routed_wake != 8'h00 |-> $past(!s2[4]) && (routed_wake & ~$past(route_en)) == 8'h00)
		else $error("wake routed while blocked");
	a_kbd_off: assert property (@(posedge mclk) disable iff (!rst_n) $past(kbd_cfg) == 4'h0 |-> !kbd_wake_event) // see (R19)
		else $error("keyboard wake while disabled");
	a_mouse_off: assert property (@(posedge mclk) disable iff (!rst_n) // see (R18)
		$past(mouse_cfg) == MOUSE_OFF |-> !mouse_wake_event && midx == 2'd0)
		else $error("mouse wake while disabled");
	a_prefix_skip: assert property (@(posedge mclk) disable iff (!rst_n) // see (R9)
		rx_valid[0] && password && kbyte == 8'hf0 |=> kpos == $past(kpos) && after_break)
		else $error("break prefix compared in password mode");
	a_wildcard_take: assert property (@(posedge mclk) disable iff (!rst_n) // see (R8)
		rx_valid[0] && !password && kbd_cfg != 4'h0 && kpos == 3'd0 && match_byte[0] == 8'h00
		|=> kpos == 3'd1 || kbd_wake_event)
		else $error("zero match byte did not accept");
	a_restart_miss: assert property (@(posedge mclk) disable iff (!rst_n) // see (R22)
		kconsider && !kmatch |=> kpos == 3'd0 && !kbd_wake_event)
		else $error("mismatch did not restart sequence");
	a_status_sticky: assert property (@(posedge mclk) disable iff (!rst_n) // see (R22)
		kbd_hit |=> status[STAT_KBD_BIT] ##1 kbd_wake_event == 1'b0 || status[STAT_KBD_BIT])
		else $error("keyboard status lost on set");
	a_parity_drop: assert property (@(posedge mclk) disable iff (!rst_n) // see (R21)
		g_rx[0].done && !parity_off && !(^g_rx[0].frame[9:1]) |=> !rx_valid[0])
		else $error("bad parity byte accepted");
endmodule : ps2_wake_detector

// ---- tb/ps2_dev_model.sv ----
// keyboard or mouse device model that sends frames to the host pins.
// assumes pull-ups on both lines, so idle and released levels read high.
`timescale 1ns/10ps
module ps2_dev_model (
	output logic link_clk,
	output logic link_data
);
	// idle: clock stands still high, data released to the pull-up
	initial begin
		link_clk = 1'b1;
		link_data = 1'b1;
	end
	// start, data lsb first, odd parity, stop; bad_par breaks parity on purpose
	task automatic send(input logic [7:0] b, input logic bad_par);
		logic [10:0] f;
		f = {1'b1, ~^b ^ bad_par, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			link_data = f[i]; // moves mid-high so it is stable at the fall
			#200 link_clk = 1'b0;
			#400 link_clk = 1'b1;
			#200;
		end
		link_data = 1'b1; // released, pull-up level
		#2000;
	endtask : send
endmodule : ps2_dev_model

// ---- tb/ps2_wake_detector_tb_top.sv ----
// self-checking bench for the wake detector: apb accesses, wake routing, link frames.
// assumes the design answers apb with no wait states and a 10 MHz mclk.
`timescale 1ns/10ps
module ps2_wake_detector_tb_top import wake_pkg::*;;
	logic mclk, rst_n, psel, penable, pwrite, main_power_good, re;
	logic [7:0] paddr, general_wake_in, routed_wake;
	logic [31:0] pwdata, prdata, rv;
	logic pready, pslverr, kbd_clk, kbd_data, mouse_clk, mouse_data, kbd_wake_event, mouse_wake_event;
	int num_errors = 0, n_tests = 0, kc = 0, mc = 0, k0 = 0, m0 = 0;

	// short double-click window keeps the run brief
	ps2_wake_detector #(.DBL_CYCLES(3000)) dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .kbd_clk(kbd_clk), .kbd_data(kbd_data),
		.mouse_clk(mouse_clk), .mouse_data(mouse_data), .main_power_good(main_power_good),
		.general_wake_in(general_wake_in), .routed_wake(routed_wake),
		.kbd_wake_event(kbd_wake_event), .mouse_wake_event(mouse_wake_event));
	ps2_dev_model kbd_u (.link_clk(kbd_clk), .link_data(kbd_data));
	ps2_dev_model mouse_u (.link_clk(mouse_clk), .link_data(mouse_data));

	// clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// pulse counters, sampled on the falling edge where outputs are settled
	always @(negedge mclk) begin
		if (kbd_wake_event === 1'b1) kc++;
		if (mouse_wake_event === 1'b1) mc++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	function automatic logic [7:0] ba(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction : ba

	// one apb transfer; request held until pready is seen high, dropped with an error after 16 cycles without it
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) num_errors++;
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic err);
		xfer(a, 1'b0, 32'h0000_0000);
		check(rv, exp);
		check({31'h0000_0000, re}, {31'h0000_0000, err});
	endtask : rdc

	// field cleared before every new setting
	task automatic set_ctrl(input logic [7:0] v);
		wr(ba(IDX_CTRL), 32'h0000_0000);
		wr(ba(IDX_CTRL), {24'h00_0000, v});
	endtask : set_ctrl

	task automatic mt(input logic [7:0] q[$]);
		foreach (q[i]) wr(ba(IDX_MATCH0 + 8'(i)), {24'h00_0000, q[i]});
	endtask : mt

	task automatic ks(input logic [7:0] q[$]);
		foreach (q[i]) kbd_u.send(q[i], 1'b0);
	endtask : ks

	task automatic mp(input logic [7:0] a, input logic [7:0] x, input logic [7:0] y);
		mouse_u.send(a, 1'b0);
		mouse_u.send(x, 1'b0);
		mouse_u.send(y, 1'b0);
	endtask : mp

	// compares wake pulses seen since the last test against the expected counts
	task automatic done(input string s, input int k, input int m);
		repeat (20) @(posedge mclk);
		check(kc - k0, k);
		check(mc - m0, m);
		k0 = kc;
		m0 = mc;
		$display("test %s finished", s);
	endtask : done

	// hang guard, well beyond the expected run of about 6000 cycles
	initial begin
		#3000000;
		num_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		main_power_good = 1'b1;
		general_wake_in = 8'h00;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rdc(ba(IDX_ROUTE_EN), 32'h0000_00ff, 1'b0);
		rdc(ba(IDX_CTRL), 32'h0000_0000, 1'b0);
		rdc(8'h04, 32'h0000_0000, 1'b1);
		rdc(8'h69, 32'h0000_0000, 1'b1);
		main_power_good <= 1'b0;
		general_wake_in <= 8'hff;
		for (int i = 0; i < 8; i++) begin
			wr(ba(IDX_ROUTE_EN), 32'(1 << i));
			repeat (4) @(posedge mclk);
			check({24'h00_0000, routed_wake}, 32'(1 << i));
		end
		main_power_good <= 1'b1;
		repeat (6) @(posedge mclk);
		check({24'h00_0000, routed_wake}, 32'h0000_0000);
		$display("test routing finished");
		wr(ba(IDX_CTRL), 32'h0000_0081);
		wr(ba(IDX_SOFT_RST), 32'h0000_0001);
		rdc(ba(IDX_ROUTE_EN), 32'h0000_00ff, 1'b0);
		rdc(ba(IDX_CTRL), 32'h0000_0000, 1'b0);
		set_ctrl(8'h01);
		mt('{8'h00, 8'h00});
		ks('{8'h1c});
		done("any key half", 0, 0);
		ks('{8'h2b});
		done("any key", 1, 0);
		ks('{8'h1c});
		kbd_u.send(8'h2b, 1'b1);
		done("parity on", 0, 0);
		set_ctrl(8'h81);
		ks('{8'h1c});
		kbd_u.send(8'h2b, 1'b1);
		done("parity off", 1, 0);
		set_ctrl(8'h09);
		mt('{8'h1c, 8'h32});
		ks('{8'h1c, 8'hf0, 8'h1c});
		done("password part", 0, 0);
		ks('{8'h32});
		done("password", 1, 0);
		set_ctrl(8'h02);
		mt('{8'he0, 8'h5b, 8'hf0});
		ks('{8'he0, 8'h5b, 8'h11});
		done("raw broken", 0, 0);
		ks('{8'he0, 8'h5b, 8'hf0});
		done("raw", 1, 0);
		rdc(ba(IDX_KBD_DATA), 32'h0000_00f0, 1'b0);
		wr(ba(IDX_CTRL), 32'h0000_0000);
		ks('{8'he0, 8'h5b, 8'hf0});
		done("kbd off", 0, 0);
		set_ctrl(8'h10);
		mp(8'h08, 8'h05, 8'h00);
		done("mouse move", 0, 1);
		set_ctrl(8'h20);
		mp(8'h0a, 8'h00, 8'h00);
		mp(8'h08, 8'h00, 8'h00);
		mp(8'h09, 8'h00, 8'h00);
		done("left press", 0, 0);
		mp(8'h08, 8'h00, 8'h00);
		done("left click", 0, 1);
		set_ctrl(8'h50);
		mp(8'h0a, 8'h00, 8'h00);
		mp(8'h08, 8'h00, 8'h00);
		done("right single", 0, 0);
		mp(8'h0a, 8'h00, 8'h00);
		mp(8'h08, 8'h00, 8'h00);
		done("right double", 0, 1);
		set_ctrl(8'h11);
		mt('{8'h00, 8'h00});
		fork
			ks('{8'h1c, 8'h2b});
			mp(8'h08, 8'h03, 8'h00);
		join
		done("both links", 1, 1);
		rdc(ba(IDX_STATUS), 32'h0000_0003, 1'b0);
		wr(ba(IDX_STATUS), 32'h0000_0003);
		rdc(ba(IDX_STATUS), 32'h0000_0000, 1'b0);
		give_verdict();
	end
endmodule : ps2_wake_detector_tb_top
